// ==== hdl/crp_response.v ====
// response primitive sequencer for the memory management coprocessor port
`timescale 1ns/1ps
`default_nettype none
`include "crp_defs.vh"

// What this block does
// - hold register transfer request until transfer done
// - pc pass bit fifteen always clear
// - supervisor check before any user state
// - reread after supervisor check means passed
// - supervisor check at most once per instruction
// - effective address request for four instructions
// - hold address request until address delivered
// - control register request fetches function code
// - control register request once per dialog
// - response read instead of select gives illegal
// - vectors 11,13 pre; 56,57,58 post
// - exception request held until acknowledge, abort or superseded
// - acknowledge clears exception, response becomes null
// - never use mid-instruction exception form
// - pre form on illegal command or violation
// - post form on privileged move, load, test, validate faults
// - come again zero in exception requests
// - advance scan counter before post exception
module crp_response (
   // clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // register port
   input  wire [3:0]  addr_in,
   input  wire [15:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [15:0] rdata_out,
   // scan program counter advance request to the host side
   output reg         scan_advance_out,
   // dialog progress
   output reg         busy_out,
   output reg  [15:0] fcode_out
);

   ////////////////////////////////////////////////////////////////////////
   // dialog overview
   //
   // the host drives every dialog by reading the response register
   // each read returns the primitive that stands at that moment
   // a primitive stands until the event that retires it
   // reads never stall; read data follow one cycle after the strobe
   //
   // idle:
   //   response reads return the null primitive
   //   a command word write starts a dialog
   //   operation codes 0 and 7 are refused at once
   //   a refused command returns the pre exception, emulator vector
   //
   // supervisor stage:
   //   entered only when the privileged bit of the command is set
   //   entered before any state that user code could observe
   //   the response read that returns the check retires it
   //   the next read is the host's confirmation of supervisor state
   //   a host that fails the check never reads again and aborts
   //   the stage is entered at most once per command word
   //
   // address stage:
   //   used by flush, load, test and validate operations
   //   the address request stands for the whole address transfer
   //   the address register takes two writes, high word first
   //   only the second write completes the transfer
   //   an injected fault turns completion into a post exception
   //   flush never faults here; it has nothing to look up
   //
   // control register stage:
   //   used by the function code move only
   //   the request is read once, then never issued again
   //   the host must next read the select register
   //   response reads before the operand write return illegal zero
   //   the operand write carries the chosen function code
   //   that write ends the dialog with the null primitive
   //
   // exception stage:
   //   the take exception primitive stands until retired
   //   an acknowledge in the control register retires it
   //   an abort in the control register retires it as well
   //   a new command word supersedes it with a protocol violation
   //   both exception forms keep come again and pc pass at zero
   //   the mid instruction form is never built
   //
   // post exceptions:
   //   the scan program counter advance pulse goes out first
   //   the pulse is one cycle long, in the cycle after the deciding strobe
   //   the primitive is visible from the following response read
   //   so the host has moved past the instruction before it stacks
   //
   // control register priority:
   //   an acknowledge in the exception stage is served first
   //   then an abort in any stage
   //   then a command word written while a dialog runs
   //   the stage logic only acts when none of these occurs
   //
   // command word layout:
   //   bits 15 to 13 select the operation
   //   bit 12 marks the operation as privileged
   //   bit 3 is returned as the function code selector
   //   bits 2 to 0, when nonzero, inject a fault for test
   //
   // exception vectors:
   //   emulator trap and protocol violation are pre exceptions
   //   configuration, illegal operation and access are post
   //   a faulting privileged register move reports configuration
   //   a faulting load or test reports illegal operation
   //   a failed pointer validation reports access violation
   //
   // hazards and limits:
   //   a command during a dialog always ends that dialog
   //   no primitive ever carries pc pass; bit 15 is masked on read
   //   the busy output lags the state by one cycle
   //   the status register shows the one-hot state for debug
   //   the register port has no wait states and no errors
   //   unmapped reads return zero, unmapped writes are dropped
   //
   // state encoding:
   //   one-hot, six stages, idle is the reset stage
   //   an illegal code falls back to idle
   ////////////////////////////////////////////////////////////////////////
   localparam S_IDLE  = 6'b000001;
   localparam S_SUPER = 6'b000010;
   localparam S_EA    = 6'b000100;
   localparam S_CREG  = 6'b001000;
   localparam S_SEL   = 6'b010000;
   localparam S_EXC   = 6'b100000;

   ////////////////////////////////////////////////////////////////////////
   // state
   reg [5:0]  state_q;
   reg [15:0] cmd_q;
   reg [15:0] prim_q;
   reg        sup_done_q;
   reg        creg_done_q;
   reg        ea_half_q;
   reg [7:0]  vec_q;
   reg        post_q;
   reg        fault_q;

   wire       wr_ctl  = wr_in && (addr_in == `CRP_REG_CONTROL);
   wire       wr_cmd  = wr_in && (addr_in == `CRP_REG_COMMAND);
   wire       wr_opnd = wr_in && (addr_in == `CRP_REG_OPERAND);
   wire       wr_addr = wr_in && (addr_in == `CRP_REG_ADDRESS);
   wire       rd_resp = rd_in && (addr_in == `CRP_REG_RESPONSE);
   wire [2:0] op      = cmd_q[15:13];

   // build an exception primitive: come again zero, pc pass zero
   function [15:0] exc_prim;
      input       post;
      input [7:0] vec;
      begin
         exc_prim = {(post ? `CRP_POST_HI : `CRP_PRE_HI), vec};
      end
   endfunction

   // decide the stage that follows the supervisor stage
   function [5:0] next_stage;
      input [2:0] opc;
      begin
         if (opc == `CRP_OP_FLUSH || opc == `CRP_OP_LOAD ||
             opc == `CRP_OP_TEST || opc == `CRP_OP_VALID) begin
            next_stage = S_EA;
         end else if (opc == `CRP_OP_FCMOVE) begin
            next_stage = S_CREG;
         end else begin
            next_stage = S_IDLE;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // dialog sequencer
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q          <= S_IDLE;
         cmd_q            <= 16'h0000;
         prim_q           <= `CRP_PRIM_NULL;
         sup_done_q       <= 1'b0;
         creg_done_q      <= 1'b0;
         ea_half_q        <= 1'b0;
         vec_q            <= 8'h00;
         post_q           <= 1'b0;
         fault_q          <= 1'b0;
         scan_advance_out <= 1'b0;
         fcode_out        <= 16'h0000;
      end else begin
         scan_advance_out <= 1'b0;
         if (wr_ctl && wdata_in[`CRP_CTL_XACK] && state_q == S_EXC) begin
            // acknowledge drops the request and returns null
            state_q <= S_IDLE;
            prim_q  <= `CRP_PRIM_NULL;
         end else if (wr_ctl && wdata_in[`CRP_CTL_ABORT]) begin
            state_q <= S_IDLE;
            prim_q  <= `CRP_PRIM_NULL;
         end else if (wr_cmd && state_q != S_IDLE) begin
            // a command mid dialog is a protocol violation
            state_q <= S_EXC;
            vec_q   <= `CRP_VEC_PROTO;
            post_q  <= 1'b0;
            prim_q  <= exc_prim(1'b0, `CRP_VEC_PROTO);
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (wr_cmd) begin
                     cmd_q       <= wdata_in;
                     sup_done_q  <= 1'b0;
                     creg_done_q <= 1'b0;
                     ea_half_q   <= 1'b0;
                     fault_q     <= |wdata_in[2:0];
                     if (wdata_in[15:13] == 3'h0 ||
                         wdata_in[15:13] == 3'h7) begin
                        state_q <= S_EXC;
                        vec_q   <= `CRP_VEC_EMUL;
                        post_q  <= 1'b0;
                        prim_q  <= exc_prim(1'b0, `CRP_VEC_EMUL);
                     end else if (wdata_in[12]) begin
                        // check privilege before touching state
                        state_q    <= S_SUPER;
                        sup_done_q <= 1'b1;
                        prim_q     <= `CRP_PRIM_SUPER;
                     end else begin
                        state_q <= next_stage(wdata_in[15:13]);
                        prim_q  <= (next_stage(wdata_in[15:13]) == S_EA) ?
                                   `CRP_PRIM_EA :
                                   (next_stage(wdata_in[15:13]) == S_CREG) ?
                                   `CRP_PRIM_CREG : `CRP_PRIM_NULL;
                     end
                  end
               end
               S_SUPER: begin
                  // the response read that returns the check retires it
                  if (rd_resp) begin
                     state_q <= next_stage(op);
                     if (next_stage(op) == S_EA) begin
                        prim_q <= `CRP_PRIM_EA;
                     end else if (next_stage(op) == S_CREG &&
                                  !creg_done_q) begin
                        prim_q <= `CRP_PRIM_CREG;
                     end else if (op == `CRP_OP_MOVE && fault_q) begin
                        scan_advance_out <= 1'b1;
                        state_q <= S_EXC;
                        vec_q   <= `CRP_VEC_CONFIG;
                        post_q  <= 1'b1;
                        prim_q  <= exc_prim(1'b1, `CRP_VEC_CONFIG);
                     end else begin
                        state_q <= S_IDLE;
                        prim_q  <= `CRP_PRIM_NULL;
                     end
                  end
               end
               S_EA: begin
                  // held until both address words have arrived
                  if (wr_addr) begin
                     ea_half_q <= ~ea_half_q;
                     if (ea_half_q) begin
                        if (fault_q && op != `CRP_OP_FLUSH) begin
                           scan_advance_out <= 1'b1;
                           state_q <= S_EXC;
                           post_q  <= 1'b1;
                           vec_q   <= (op == `CRP_OP_VALID) ?
                                      `CRP_VEC_ACCESS : `CRP_VEC_ILLOP;
                           prim_q  <= exc_prim(1'b1,
                                      (op == `CRP_OP_VALID) ?
                                      `CRP_VEC_ACCESS :
                                      `CRP_VEC_ILLOP);
                        end else begin
                           state_q <= S_IDLE;
                           prim_q  <= `CRP_PRIM_NULL;
                        end
                     end
                  end
               end
               S_CREG: begin
                  if (rd_resp) begin
                     // request seen; only one issue per dialog
                     state_q     <= S_SEL;
                     creg_done_q <= 1'b1;
                     prim_q      <= `CRP_PRIM_ILLEGAL;
                  end
               end
               S_SEL: begin
                  if (wr_opnd) begin
                     fcode_out <= wdata_in;
                     state_q   <= S_IDLE;
                     prim_q    <= `CRP_PRIM_NULL;
                  end
               end
               S_EXC: begin
                  prim_q <= exc_prim(post_q, vec_q);
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data one cycle after the strobe
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 16'h0000;
         busy_out  <= 1'b0;
      end else begin
         busy_out <= (state_q != S_IDLE);
         if (rd_in) begin
            if (addr_in == `CRP_REG_RESPONSE) begin
               // bit 15 forced clear for every primitive
               rdata_out <= prim_q & 16'h7fff;
            end else if (addr_in == `CRP_REG_SELECT) begin
               rdata_out <= {15'h0000, cmd_q[3]};
            end else if (addr_in == `CRP_REG_COMMAND) begin
               rdata_out <= cmd_q;
            end else if (addr_in == `CRP_REG_STATUS) begin
               // stage flags beside the one-hot state
               rdata_out <= {8'h00, sup_done_q, creg_done_q, state_q};
            end else begin
               rdata_out <= 16'h0000;
            end
         end else begin
            rdata_out <= 16'h0000;
         end
      end
   end

endmodule
`default_nettype wire

// ==== shared/crp_defs.vh ====
// constants for the coprocessor response primitive generator
`ifndef CRP_DEFS_VH
`define CRP_DEFS_VH

// register indices on the plain register port
`define CRP_REG_RESPONSE  4'h0
`define CRP_REG_CONTROL   4'h1
`define CRP_REG_SELECT    4'h2
`define CRP_REG_OPERAND   4'h3
`define CRP_REG_ADDRESS   4'h4
`define CRP_REG_COMMAND   4'h5
`define CRP_REG_STATUS    4'h6

// control register bits
`define CRP_CTL_ABORT     1
`define CRP_CTL_XACK      0

// primitive encodings
`define CRP_PRIM_NULL     16'h0802
`define CRP_PRIM_BUSY     16'h8800
`define CRP_PRIM_SUPER    16'h8400
`define CRP_PRIM_EA       16'h0a00
`define CRP_PRIM_CREG     16'h0d00
`define CRP_PRIM_ILLEGAL  16'h0000
`define CRP_PRE_HI        8'h1c
`define CRP_POST_HI       8'h1e
`define CRP_CA_BIT        14
`define CRP_PC_BIT        15

// exception vectors
`define CRP_VEC_EMUL      8'h0b
`define CRP_VEC_PROTO     8'h0d
`define CRP_VEC_CONFIG    8'h38
`define CRP_VEC_ILLOP     8'h39
`define CRP_VEC_ACCESS    8'h3a

// command word fields: [15:13] operation, [12] privileged, [2:0] fault
`define CRP_OP_FLUSH      3'h1
`define CRP_OP_LOAD       3'h2
`define CRP_OP_TEST       3'h3
`define CRP_OP_VALID      3'h4
`define CRP_OP_MOVE       3'h5
`define CRP_OP_FCMOVE     3'h6

`endif

// ==== verification/crp_host.sv ====
// host processor model driving the coprocessor register port
`timescale 1ns/1ps
`default_nettype none
module crp_host (
   // clock
   input  wire logic        clk_in,
   // register port toward the coprocessor
   input  wire logic [15:0] rdata_in,
   output var  logic [3:0]  addr_out,
   output var  logic [15:0] wdata_out,
   output var  logic        wr_out,
   output var  logic        rd_out
);
   // bus quiet at time zero
   initial begin
      addr_out  = 4'h0;
      wdata_out = 16'h0000;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   // one write cycle, changed just after an edge
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      rd_out    <= 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   // one read cycle, data taken in the following cycle
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      addr_out <= a;
      wr_out   <= 1'b0;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      #1;
      d = rdata_in;
   endtask
   // release the strobes for one cycle
   task automatic idle();
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   // exception acknowledge into the control register
   task automatic ack();
      wr_reg(4'h1, 16'h0001);
   endtask
   // words stacked for the last exception taken
   int frame_words = 0;
   // take an exception: four-word pre frame, six-word post frame
   task automatic take_exc(input logic [15:0] prim);
      frame_words = prim[9] ? 6 : 4;
      ack();
   endtask
   // read the selector, then hand over the chosen function code
   task automatic fc_service(input logic [15:0] source_function_code_reg, input logic [15:0] dfc);
      logic [15:0] s;
      rd_reg(4'h2, s);
      wr_reg(4'h3, (s != 16'h0000) ? dfc : source_function_code_reg);
   endtask
endmodule
`default_nettype wire

// ==== verification/crp_response_properties.sv ====
// assertions on the register port of the response primitive sequencer
`timescale 1ns/1ps
`default_nettype none
module crp_response_properties (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // register port
   input wire logic [3:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   // dialog outputs
   input wire logic        scan_advance_out,
   input wire logic        busy_out,
   input wire logic [15:0] fcode_out
);
   logic sup_q;
   logic creg_q;
   logic adv_q;
   wire  exc = (rdata_out[15:10] == 6'b00_0111);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // once-per-dialog trackers, cleared by a new command word
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in || (wr_in && addr_in == 4'h5)) begin
         sup_q  <= 1'b0;
         creg_q <= 1'b0;
         adv_q  <= 1'b0;
      end else begin
         sup_q  <= sup_q | (rdata_out == 16'h0400);
         creg_q <= creg_q | (rdata_out == 16'h0d00);
         adv_q  <= adv_q | scan_advance_out;
      end
   end
   a_pc_clear: assert property (rdata_out[15] == 1'b0)
      else $error("pass flag set in read data");
   a_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
      else $error("read data outside read slot");
   a_super_once: assert property (rdata_out == 16'h0400 |-> !sup_q)
      else $error("second supervisor check");
   a_creg_once: assert property (rdata_out == 16'h0d00 |-> !creg_q)
      else $error("second control register request");
   a_creg_illegal: assert property (rdata_out == 16'h0d00 && rd_in &&
      addr_in == 4'h0 |=> rdata_out <= 16'h0001)
      else $error("response reread not illegal");
   a_pre_vector: assert property (rdata_out[15:8] == 8'h1c |->
      rdata_out[7:0] inside {8'h0b, 8'h0d})
      else $error("bad pre exception vector");
   a_post_vector: assert property (rdata_out[15:8] == 8'h1e |->
      rdata_out[7:0] inside {8'h38, 8'h39, 8'h3a} && adv_q)
      else $error("bad post exception or no advance");
   a_no_mid: assert property (rdata_out[15:8] != 8'h1d)
      else $error("mid instruction form used");
   a_exc_holds: assert property (exc && rd_in && addr_in == 4'h0 |=>
      rdata_out == $past(rdata_out))
      else $error("exception request dropped");
   a_ack_null: assert property (exc && wr_in && addr_in == 4'h1 &&
      wdata_in[0] ##1 rd_in && addr_in == 4'h0 |=> rdata_out == 16'h0802)
      else $error("acknowledge did not give null");
   a_ea_hold: assert property (rdata_out == 16'h0a00 && rd_in &&
      addr_in == 4'h0 |=> rdata_out == 16'h0a00)
      else $error("address request dropped early");
   a_adv_pulse: assert property (scan_advance_out |=> !scan_advance_out)
      else $error("advance longer than one cycle");
endmodule
`default_nettype wire

// ==== verification/crp_response_tb.sv ====
// self-checking bench for the response primitive sequencer
`timescale 1ns/1ps
`default_nettype none
module crp_response_tb;
   logic        clk_in;
   logic        rst_in;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] fcode;
   logic        wr;
   logic        rd;
   logic        adv;
   logic        busy;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          advs = 0;
   int          i;
   crp_response u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .scan_advance_out(adv), .busy_out(busy), .fcode_out(fcode));
   crp_host u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   // 10 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // cycle and advance counts, hang limit
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (adv === 1'b1) advs <= advs + 1;
      if (cycles > 3000) begin
         bad_count = bad_count + 1;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      u_host.rd_reg(a, v);
      check(v, e);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst_in = 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      rchk(4'h0, 16'h0802);
      check({15'h0000, busy}, 16'h0000);
      rchk(4'hf, 16'h0000);
      // address dialogs for all four ops, the first one privileged
      for (i = 1; i < 5; i++) begin
         u_host.wr_reg(4'h5, {i[2:0], i == 1, 12'h000});
         if (i == 1) rchk(4'h0, 16'h0400);
         rchk(4'h0, 16'h0a00);
         rchk(4'h0, 16'h0a00);
         u_host.wr_reg(4'h4, 16'h1234);
         rchk(4'h0, 16'h0a00);
         u_host.wr_reg(4'h4, 16'h5678);
         rchk(4'h0, 16'h0802);
      end
      // function code fetch, with a stray response read
      u_host.wr_reg(4'h5, 16'hc000);
      rchk(4'h0, 16'h0d00);
      rchk(4'h0, 16'h0000);
      u_host.fc_service(16'h0005, 16'h0006);
      u_host.idle();
      check(fcode, 16'h0005);
      rchk(4'h0, 16'h0802);
      // illegal command words, cleared by acknowledge then abort
      for (i = 0; i < 2; i++) begin
         u_host.wr_reg(4'h5, i ? 16'he000 : 16'h0000);
         rchk(4'h0, 16'h1c0b);
         rchk(4'h0, 16'h1c0b);
         if (i) u_host.wr_reg(4'h1, 16'h0002);
         else u_host.ack();
         rchk(4'h0, 16'h0802);
      end
      // command rewritten mid dialog
      u_host.wr_reg(4'h5, 16'h4000);
      rchk(4'h0, 16'h0a00);
      check({15'h0000, busy}, 16'h0001);
      u_host.wr_reg(4'h5, 16'h4000);
      rchk(4'h0, 16'h1c0d);
      u_host.take_exc(16'h1c0d);
      check(u_host.frame_words[15:0], 16'h0004);
      rchk(4'h0, 16'h0802);
      // faults on load, test and validate
      for (i = 2; i < 5; i++) begin
         u_host.wr_reg(4'h5, {i[2:0], 13'h0001});
         rchk(4'h0, 16'h0a00);
         u_host.wr_reg(4'h4, 16'h0000);
         u_host.wr_reg(4'h4, 16'h0000);
         rchk(4'h0, (i == 4) ? 16'h1e3a : 16'h1e39);
         check(advs[15:0], 16'(i - 1));
         u_host.take_exc(16'h1e39);
         check(u_host.frame_words[15:0], 16'h0006);
         rchk(4'h0, 16'h0802);
      end
      // faulting privileged register move
      u_host.wr_reg(4'h5, 16'hb001);
      rchk(4'h0, 16'h0400);
      rchk(4'h0, 16'h1e38);
      check(advs[15:0], 16'h0004);
      u_host.take_exc(16'h1e38);
      rchk(4'h0, 16'h0802);
      u_host.idle();
      print_verdict();
   end
endmodule
bind crp_response crp_response_properties u_props (.clk_in(clk_in),
   .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .scan_advance_out(scan_advance_out), .busy_out(busy_out),
   .fcode_out(fcode_out));
`default_nettype wire
